/* pkg/dct_pkg.sv */
// Shared constants for the dual compare timer: register map, field
// positions, reset values and divider selections.
// Assumes a 32-bit classic Wishbone slave with byte addressing.
package dct_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_RUN_CTRL   = 8'h00; // counter_run_control
    localparam logic [7:0] OFS_OUT_CFG    = 8'h04; // output_control_config
    localparam logic [7:0] OFS_CC_SETUP   = 8'h08; // capture_compare_setup
    localparam logic [7:0] OFS_COUNT      = 8'h0c; // main_count_value, read only
    localparam logic [7:0] OFS_MATCH0     = 8'h10; // match_value_register 0
    localparam logic [7:0] OFS_MATCH1     = 8'h14; // match_value_register 1
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h18; // Sticky events, read clears
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h1c; // Same layout as status

    // counter_run_control fields
    localparam int RUN_EN_BIT   = 0;  // count_enable_bit
    localparam int RUN_DIV_LSB  = 1;  // clock_divider_select, 4 bits
    localparam int DIV_SEL_W    = 4;

    // output_control_config fields, channel n at bit n*OUT_CH_STRIDE
    localparam int OUT_EN_OFS   = 0;  // output_enable_bit
    localparam int OUT_ALV_OFS  = 1;  // active_level_bit
    localparam int OUT_PWM_OFS  = 2;  // 1: PWM, 0: toggle on match
    localparam int OUT_CH_STRIDE = 4;
    localparam int OUT_CFG_W    = 8;

    // capture_compare_setup fields: bit n clears the count on match n
    localparam int CC_SETUP_W   = 2;

    // Interrupt status and mask bits
    localparam int IRQ_MATCH0_BIT = 0;
    localparam int IRQ_MATCH1_BIT = 1;
    localparam int IRQ_EDGE_BIT   = 2;
    localparam int IRQ_W          = 3;

    // Divider selections: count clock is clk divided by 2**(sel+2) for sel 1 to 9
    localparam logic [3:0] DIV_SEL_EXT   = 4'h0; // external_edge_input
    localparam logic [3:0] DIV_SEL_MAX   = 4'h9; // clk/2048
    localparam int         DIV_EXP_BASE  = 2;

    // Reset values
    localparam logic [15:0] COUNT_RST     = 16'h0000;
    localparam logic [15:0] MATCH_RST     = 16'hffff;
    localparam logic [3:0]  DIV_SEL_RST   = 4'h1;    // clk/8
    localparam logic [7:0]  OUT_CFG_RST   = 8'h00;
    localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;

endpackage

/* core/dct_prescaler.sv */
// Count clock prescaler: one-cycle tick every 2**(sel+2) clocks for sel 1 to 9, else every 2048.
// Assumes run is a registered level; the divider restarts while stopped.
`timescale 1ns/1ns
`default_nettype none
module dct_prescaler #(
    parameter int DIV_W = 11
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           run,
    input  wire logic [dct_pkg::DIV_SEL_W-1:0]  sel,
    output logic                                tick
);
    logic [DIV_W-1:0] divCnt_reg;
    logic [DIV_W-1:0] terminal;

    initial begin
        if (DIV_W < 11) begin
            $error("dct_prescaler: DIV_W too small for divide by 2048");
        end
    end

    // Terminal count for the selected ratio; selection 0 and selections above DIV_SEL_MAX keep the all-ones terminal and tick every 2048 clocks
    always_comb begin
        terminal = '1;
        if (sel != dct_pkg::DIV_SEL_EXT && sel <= dct_pkg::DIV_SEL_MAX) begin
            terminal = DIV_W'((32'd1 << (32'(sel) + dct_pkg::DIV_EXP_BASE)) - 32'd1);
        end
    end

    // Held at zero while stopped, so a start always waits one full count clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt_reg <= '0;
            tick       <= 1'b0;
        end else if (!run) begin
            divCnt_reg <= '0;
            tick       <= 1'b0;
        end else if (divCnt_reg == terminal) begin
            divCnt_reg <= '0;
            tick       <= 1'b1;
        end else begin
            divCnt_reg <= divCnt_reg + DIV_W'(1);
            tick       <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* core/dct_timer.sv */
// Dual compare timer: 16-bit up-counter, two match registers, two timer
// output pins, event counting from an edge input, Wishbone register access.
// Assumes the edge input is synchronous to clk and the bus is classic
// Wishbone, 32-bit data, byte addressed.
//
// How it works
// - Stop coinciding with a match still raises request.
// - Start may lag one count clock; later exact.
// - Match write suppresses that register's match detection.
// - Matches detected only when the counter increments.
// - Disabled output drives inverse of its active level.
// - Event count reads zero before and after first edge.
`timescale 1ns/1ns
`default_nettype none
module dct_timer #(
    parameter int CNT_W = 16,
    parameter int DIV_W = 11
) (
    input  wire logic        clk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Timer pins and event input
    input  wire logic        externalEdgeInput,
    output logic      [1:0]  timerOutputPin,
    output logic             irq
);
    initial begin
        if (CNT_W != 16) begin
            $error("dct_timer: only a 16-bit counter is supported");
        end
    end

    logic [CNT_W-1:0]              count_reg;
    logic [CNT_W-1:0]              match_reg [2];
    logic                          runEnable_reg;
    logic [dct_pkg::DIV_SEL_W-1:0] divSel_reg;
    logic [dct_pkg::OUT_CFG_W-1:0] outCfg_reg;
    logic [dct_pkg::CC_SETUP_W-1:0] ccSetup_reg;
    logic [dct_pkg::IRQ_W-1:0]     irqStat_reg;
    logic [dct_pkg::IRQ_W-1:0]     irqStat_next;
    logic [dct_pkg::IRQ_W-1:0]     irqMask_reg;
    logic [1:0]                    outState_reg;
    logic                          edgeIn_reg;
    logic                          extArmed_reg;
    logic                          prescTick;
    logic                          edgeSeen;
    logic                          countTick;
    logic                          extMode;
    logic                          access;
    logic                          wrAccess;
    logic                          rdStatus;
    logic [1:0]                    wrMatch;
    logic [1:0]                    hit;
    logic                          wrap;
    logic [CNT_W-1:0]              countInc;

    // A match fires on an increment into the match value, never on a write
    function automatic logic matchHit(input logic tick, input logic writing,
                                      input logic [15:0] nextVal, input logic [15:0] matchVal);
        matchHit = tick && !writing && (nextVal == matchVal);
    endfunction

    // Channel configuration field pick
    function automatic logic cfgBit(input logic [7:0] cfg, input int ch, input int ofs);
        cfgBit = cfg[ch * dct_pkg::OUT_CH_STRIDE + ofs];
    endfunction

    // Bus decode: the access is taken on the edge that raises ack
    assign access   = cyc_i && stb_i && !ack_o;
    assign wrAccess = access && we_i;
    assign rdStatus = access && !we_i && adr_i == dct_pkg::OFS_IRQ_STAT;
    assign wrMatch[0] = wrAccess && adr_i == dct_pkg::OFS_MATCH0 && sel_i[1:0] != 2'h0;
    assign wrMatch[1] = wrAccess && adr_i == dct_pkg::OFS_MATCH1 && sel_i[1:0] != 2'h0;

    dct_prescaler #(
        .DIV_W (DIV_W)
    ) u_presc (
        .clk  (clk),
        .rst  (rst),
        .run  (runEnable_reg),
        .sel  (divSel_reg),
        .tick (prescTick)
    );

    // Event mode: the first edge after start only arms the counter
    assign extMode   = divSel_reg == dct_pkg::DIV_SEL_EXT;
    assign edgeSeen  = externalEdgeInput && !edgeIn_reg;
    assign countTick = runEnable_reg && (extMode ? (edgeSeen && extArmed_reg) : prescTick);
    assign countInc  = count_reg + CNT_W'(1);

    // Clear-on-match restarts from zero; the clear itself is no match event
    always_comb begin
        wrap = countTick && count_reg == '1;
        for (int n = 0; n < 2; n++) begin
            hit[n] = matchHit(countTick, wrMatch[n], countInc, match_reg[n]);
        end
    end

    // Edge history and arming for event counting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            edgeIn_reg   <= 1'b0;
            extArmed_reg <= 1'b0;
        end else begin
            edgeIn_reg <= externalEdgeInput;
            if (!runEnable_reg) begin
                extArmed_reg <= 1'b0;
            end else if (extMode && edgeSeen) begin
                extArmed_reg <= 1'b1;
            end
        end
    end

    // Main counter; a stop write takes effect after this edge's increment
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= dct_pkg::COUNT_RST;
        end else if (countTick) begin
            if ((ccSetup_reg[0] && count_reg == match_reg[0]) ||
                (ccSetup_reg[1] && count_reg == match_reg[1])) begin
                count_reg <= '0;
            end else begin
                count_reg <= countInc;
            end
        end
    end

    // Control and configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            runEnable_reg <= 1'b0;
            divSel_reg    <= dct_pkg::DIV_SEL_RST;
            outCfg_reg    <= dct_pkg::OUT_CFG_RST;
            ccSetup_reg   <= '0;
            irqMask_reg   <= dct_pkg::IRQ_MASK_RST;
        end else if (wrAccess && sel_i[0]) begin
            case (adr_i)
                dct_pkg::OFS_RUN_CTRL: begin
                    runEnable_reg <= dat_i[dct_pkg::RUN_EN_BIT];
                    divSel_reg    <= dat_i[dct_pkg::RUN_DIV_LSB +: dct_pkg::DIV_SEL_W];
                end
                dct_pkg::OFS_OUT_CFG:  outCfg_reg  <= dat_i[dct_pkg::OUT_CFG_W-1:0];
                dct_pkg::OFS_CC_SETUP: ccSetup_reg <= dat_i[dct_pkg::CC_SETUP_W-1:0];
                dct_pkg::OFS_IRQ_MASK: irqMask_reg <= dat_i[dct_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Match registers, byte lanes honoured; contents change only on a write or when reset loads MATCH_RST
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            match_reg[0] <= dct_pkg::MATCH_RST;
            match_reg[1] <= dct_pkg::MATCH_RST;
        end else begin
            for (int n = 0; n < 2; n++) begin
                if (wrMatch[n] && sel_i[0]) begin
                    match_reg[n][7:0] <= dat_i[7:0];
                end
                if (wrMatch[n] && sel_i[1]) begin
                    match_reg[n][15:8] <= dat_i[15:8];
                end
            end
        end
    end

    // Sticky events: a new event in the clearing cycle survives the read
    always_comb begin
        irqStat_next = rdStatus ? '0 : irqStat_reg;
        irqStat_next[dct_pkg::IRQ_MATCH0_BIT] = irqStat_next[dct_pkg::IRQ_MATCH0_BIT] | hit[0];
        irqStat_next[dct_pkg::IRQ_MATCH1_BIT] = irqStat_next[dct_pkg::IRQ_MATCH1_BIT] | hit[1];
        irqStat_next[dct_pkg::IRQ_EDGE_BIT]   = irqStat_next[dct_pkg::IRQ_EDGE_BIT] | edgeSeen;
    end

    // Status register and level interrupt, both flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqStat_reg <= '0;
            irq         <= 1'b0;
        end else begin
            irqStat_reg <= irqStat_next;
            irq         <= |(irqStat_next & irqMask_reg);
        end
    end

    // Output state: toggle on match, or PWM active at wrap and idle at match
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outState_reg <= 2'h0;
        end else begin
            for (int n = 0; n < 2; n++) begin
                if (cfgBit(outCfg_reg, n, dct_pkg::OUT_PWM_OFS)) begin
                    if (hit[n]) begin
                        outState_reg[n] <= 1'b0;
                    end else if (wrap) begin
                        outState_reg[n] <= 1'b1;
                    end
                end else if (hit[n]) begin
                    outState_reg[n] <= !outState_reg[n];
                end
            end
        end
    end

    // Pin level: a disabled pin shows the inverse of its active level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timerOutputPin <= 2'h3; // Active level bits reset low
        end else begin
            for (int n = 0; n < 2; n++) begin
                if (cfgBit(outCfg_reg, n, dct_pkg::OUT_EN_OFS)) begin
                    timerOutputPin[n] <= outState_reg[n] ~^ cfgBit(outCfg_reg, n, dct_pkg::OUT_ALV_OFS);
                end else begin
                    timerOutputPin[n] <= !cfgBit(outCfg_reg, n, dct_pkg::OUT_ALV_OFS);
                end
            end
        end
    end

    // Bus answer: one-cycle ack, registered read data, zero when unmapped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= access;
            if (access && !we_i) begin
                case (adr_i)
                    dct_pkg::OFS_RUN_CTRL: dat_o <= 32'({divSel_reg, runEnable_reg});
                    dct_pkg::OFS_OUT_CFG:  dat_o <= 32'(outCfg_reg);
                    dct_pkg::OFS_CC_SETUP: dat_o <= 32'(ccSetup_reg);
                    dct_pkg::OFS_COUNT:    dat_o <= 32'(count_reg);
                    dct_pkg::OFS_MATCH0:   dat_o <= 32'(match_reg[0]);
                    dct_pkg::OFS_MATCH1:   dat_o <= 32'(match_reg[1]);
                    dct_pkg::OFS_IRQ_STAT: dat_o <= 32'(irqStat_reg);
                    dct_pkg::OFS_IRQ_MASK: dat_o <= 32'(irqMask_reg);
                    default:               dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* test/dct_timer_props.sv */
// Checker for dct_timer: bus handshake, pin levels, interrupt relations.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module dct_timer_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        externalEdgeInput,
    input wire logic [1:0]  timerOutputPin,
    input wire logic        irq
);
    logic       taken;
    logic       wrOk;
    logic [7:0] cfg_reg;
    logic [1:0] cfgAge_reg;
    logic [2:0] mask_reg;
    logic [1:0] maskAge_reg;

    // Accepted requests; ages saturate so only settled setups are judged
    assign taken = cyc_i && stb_i && !ack_o;
    assign wrOk = taken && we_i && sel_i[0];

    // Output setup as software last wrote it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= dct_pkg::OUT_CFG_RST;
            cfgAge_reg <= 2'h3;
        end else if (wrOk && adr_i == dct_pkg::OFS_OUT_CFG) begin
            cfg_reg <= dat_i[7:0];
            cfgAge_reg <= 2'h0;
        end else if (cfgAge_reg != 2'h3) begin
            cfgAge_reg <= cfgAge_reg + 2'h1;
        end
    end

    // Interrupt mask as software last wrote it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_reg <= dct_pkg::IRQ_MASK_RST;
            maskAge_reg <= 2'h0;
        end else if (wrOk && adr_i == dct_pkg::OFS_IRQ_MASK) begin
            mask_reg <= dat_i[2:0];
            maskAge_reg <= 2'h0;
        end else if (maskAge_reg != 2'h3) begin
            maskAge_reg <= maskAge_reg + 2'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence sAckPulse; ack_o ##1 !ack_o; endsequence
    sequence sIrqSoon; ##[1:4] irq; endsequence

    AST_ACK_PULSE: assert property (taken |=> sAckPulse)
        else $error("ack is not a single-cycle answer");
    AST_ACK_IDLE: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without a request");
    AST_UNMAPPED_ZERO: assert property (taken && !we_i && adr_i > dct_pkg::OFS_IRQ_MASK |=> dat_o == 32'h0)
        else $error("unmapped read returned nonzero data");
    AST_DAT_HOLD: assert property (taken && we_i |=> $stable(dat_o))
        else $error("read data changed on a write");
    AST_RESET_PINS: assert property ($fell(rst) |-> timerOutputPin == 2'h3 && !irq)
        else $error("pins or irq wrong after reset");
    AST_DISABLED_PIN: assert property (cfgAge_reg == 2'h3 |->
        (cfg_reg[0] || timerOutputPin[0] == !cfg_reg[1]) && (cfg_reg[4] || timerOutputPin[1] == !cfg_reg[5]))
        else $error("disabled pin not at inverse active level");
    AST_IRQ_MASKED: assert property (irq |-> $past(mask_reg) != 3'h0)
        else $error("irq raised with all sources masked");
    AST_EDGE_IRQ: assert property ($rose(externalEdgeInput) && mask_reg[2] && maskAge_reg == 2'h3 |-> sIrqSoon)
        else $error("edge event raised no interrupt");
endmodule
`default_nettype wire

/* test/dct_timer_tb.sv */
// Bench for dct_timer: register table, pins, match timing, event mode.
// Assumes the one-cycle Wishbone answer and 32-clock match period below.
`timescale 1ns/1ns
`default_nettype none
module dct_timer_tb;
    typedef struct {logic [7:0] adr; logic we; logic [31:0] wd; logic [31:0] exp;} dct_row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic        ack;
    logic        ext = 1'b0;
    logic [1:0]  pin;
    logic        irq;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          cycN = 0;
    int          t0;
    int          t1;
    int          tEn;
    dct_row_t    rows [8];

    dct_timer dut_u (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .externalEdgeInput(ext), .timerOutputPin(pin), .irq(irq));

    // Clock at 25 MHz
    initial begin
        forever #20 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One classic cycle; holds the request until ack is sampled high.
    // No local bound: only the bench watchdog may end a stuck wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask

    // Waits until irq is seen high; t0 is the first edge that sees it high
    task automatic waitIrq;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq !== 1'b1 && n < 200);
        t0 = cycN;
        if (n >= 200) chk("irq", 32'h0, 32'h1);
    endtask

    // Clears stale status first so t0 is the first edge that sees irq high;
    // the write is then taken 31 edges later, on the edge of the next match
    task automatic alignWr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b0, dct_pkg::OFS_IRQ_STAT, 32'h0);
        waitIrq();
        wb(1'b0, dct_pkg::OFS_IRQ_STAT, 32'h0);
        while (cycN != t0 + 29) @(posedge clk);
        wb(1'b1, a, d);
    endtask

    task automatic pulse;
        @(posedge clk);
        ext <= 1'b1;
        repeat (2) @(posedge clk);
        ext <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Cycle count and hang guard
    always @(posedge clk) begin
        cycN <= cycN + 1;
        if (cycN == 5000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        rows = '{'{dct_pkg::OFS_OUT_CFG, 1'b0, 32'h0, 32'h0}, '{dct_pkg::OFS_MATCH0, 1'b0, 32'h0, 32'hffff},
            '{dct_pkg::OFS_RUN_CTRL, 1'b0, 32'h0, 32'h2}, '{dct_pkg::OFS_COUNT, 1'b0, 32'h0, 32'h0},
            '{dct_pkg::OFS_IRQ_MASK, 1'b0, 32'h0, 32'h0}, '{8'h20, 1'b1, 32'h5, 32'h0},
            '{dct_pkg::OFS_COUNT, 1'b1, 32'h1234, 32'h0}, '{dct_pkg::OFS_MATCH1, 1'b1, 32'habcd, 32'habcd}};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("pins", {30'h0, pin}, 32'h3);
        foreach (rows[i]) begin
            if (rows[i].we) wb(1'b1, rows[i].adr, rows[i].wd);
            rc("row", rows[i].adr, rows[i].exp);
        end
        wb(1'b1, dct_pkg::OFS_OUT_CFG, 32'h62);
        repeat (3) @(posedge clk);
        chk("pins", {30'h0, pin}, 32'h0);
        wb(1'b1, dct_pkg::OFS_MATCH0, 32'h3);
        wb(1'b1, dct_pkg::OFS_CC_SETUP, 32'h1);
        wb(1'b1, dct_pkg::OFS_IRQ_MASK, 32'h1);
        wb(1'b1, dct_pkg::OFS_RUN_CTRL, 32'h3);
        tEn = cycN;
        waitIrq();
        chk("first", 32'((t0 - tEn) inside {[24:34]}), 32'h1);
        t1 = t0;
        wb(1'b0, dct_pkg::OFS_IRQ_STAT, 32'h0);
        waitIrq();
        chk("period", 32'(t0 - t1), 32'd32);
        alignWr(dct_pkg::OFS_MATCH0, 32'h3);
        rc("stat", dct_pkg::OFS_IRQ_STAT, 32'h0);
        alignWr(dct_pkg::OFS_RUN_CTRL, 32'h2);
        chk("irq", {31'h0, irq}, 32'h1);
        rc("stat", dct_pkg::OFS_IRQ_STAT, 32'h1);
        rc("count", dct_pkg::OFS_COUNT, 32'h3);
        rc("count", dct_pkg::OFS_COUNT, 32'h3);
        wb(1'b1, dct_pkg::OFS_IRQ_MASK, 32'h3);
        wb(1'b1, dct_pkg::OFS_MATCH1, 32'h3);
        rc("stat", dct_pkg::OFS_IRQ_STAT, 32'h0);
        // Matches masked before the stop: status still records them, irq stays low
        wb(1'b1, dct_pkg::OFS_IRQ_MASK, 32'h0);
        wb(1'b1, dct_pkg::OFS_RUN_CTRL, 32'h3);
        repeat (40) @(posedge clk);
        wb(1'b1, dct_pkg::OFS_MATCH1, 32'h1);
        wb(1'b1, dct_pkg::OFS_RUN_CTRL, 32'h2);
        chk("irq", {31'h0, irq}, 32'h0);
        rc("stat", dct_pkg::OFS_IRQ_STAT, 32'h3);
        rc("match1", dct_pkg::OFS_MATCH1, 32'h1);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("pins", {30'h0, pin}, 32'h3);
        rc("count", dct_pkg::OFS_COUNT, 32'h0);
        wb(1'b1, dct_pkg::OFS_IRQ_MASK, 32'h4);
        wb(1'b1, dct_pkg::OFS_RUN_CTRL, 32'h1);
        rc("count", dct_pkg::OFS_COUNT, 32'h0);
        pulse();
        chk("irq", {31'h0, irq}, 32'h1);
        rc("stat", dct_pkg::OFS_IRQ_STAT, 32'h4);
        rc("count", dct_pkg::OFS_COUNT, 32'h0);
        wb(1'b1, dct_pkg::OFS_IRQ_MASK, 32'h0);
        pulse();
        chk("irq", {31'h0, irq}, 32'h0);
        rc("stat", dct_pkg::OFS_IRQ_STAT, 32'h4);
        rc("count", dct_pkg::OFS_COUNT, 32'h1);
        print_verdict();
    end
endmodule

bind dct_timer dct_timer_props chk_u (.clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .externalEdgeInput(externalEdgeInput), .timerOutputPin(timerOutputPin), .irq(irq));
`default_nettype wire
